//--- switch_cfg_pkg.sv
`default_nettype none
package switch_cfg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  // poll window times in ns, plain defaults
  localparam int unsigned GND_POLL_WINDOW_NS = 64000;
  localparam int unsigned BAT_POLL_WINDOW_NS = 128000;
  localparam int unsigned GND_POLL_WINDOW_CYC =
    (GND_POLL_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BAT_POLL_WINDOW_CYC =
    (BAT_POLL_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_MSB = 31;
  localparam int unsigned ADDR_LSB = 25;
  localparam int unsigned RW_BIT = 24;
  localparam int unsigned REPLY_FAULT_BIT = 23;
  localparam int unsigned REPLY_FLAG_BIT = 22;
  localparam int unsigned REPLY_DATA_W = 22;
  localparam logic RW_WRITE = 1'b1;

  localparam logic [6:0] ADDR_SP_IRQ_MASK = 7'h0D;
  localparam logic [6:0] ADDR_SG_IRQ_MASK = 7'h0E;
  localparam logic [6:0] ADDR_LPM_CONFIG = 7'h0F;

  localparam int unsigned SP_COUNT = 8;
  localparam int unsigned SG_COUNT = 14;
  localparam logic [7:0] SP_MASK_RESET = 8'hFF;
  localparam logic [13:0] SG_MASK_RESET = 14'h3FFF;
  localparam int unsigned WAKE_LSB = 4;
  localparam int unsigned POLL_LSB = 0;
  localparam int unsigned CODE_W = 4;
  localparam logic [3:0] WAKE_CODE_RESET = 4'h0;
  localparam logic [3:0] POLL_CODE_RESET = 4'hF;
  localparam logic [3:0] WAKE_CODE_OFF = 4'h0;
  localparam int unsigned MS_W = 10;

  typedef enum logic {NORMAL_MODE, LOW_POWER_MODE} power_mode_t;

  function automatic logic [9:0] wake_period_ms(input logic [3:0] code);
    unique case (code)
      4'h0: wake_period_ms = 10'h000;
      4'h1: wake_period_ms = 10'd6;
      4'h2: wake_period_ms = 10'd12;
      4'h3: wake_period_ms = 10'd24;
      4'h4: wake_period_ms = 10'd48;
      4'h5: wake_period_ms = 10'd96;
      4'h6: wake_period_ms = 10'd192;
      4'h7: wake_period_ms = 10'd394;
      4'h8: wake_period_ms = 10'd4;
      4'h9: wake_period_ms = 10'd8;
      4'hA: wake_period_ms = 10'd16;
      4'hB: wake_period_ms = 10'd32;
      4'hC: wake_period_ms = 10'd64;
      4'hD: wake_period_ms = 10'd128;
      4'hE: wake_period_ms = 10'd256;
      4'hF: wake_period_ms = 10'd512;
    endcase
  endfunction

  function automatic logic [9:0] poll_period_ms(input logic [3:0] code);
    unique case (code)
      4'h0: poll_period_ms = 10'd3;
      4'h1: poll_period_ms = 10'd6;
      4'h2: poll_period_ms = 10'd12;
      4'h3: poll_period_ms = 10'd24;
      4'h4: poll_period_ms = 10'd48;
      4'h5: poll_period_ms = 10'd68;
      4'h6: poll_period_ms = 10'd76;
      4'h7: poll_period_ms = 10'd128;
      4'h8: poll_period_ms = 10'd32;
      4'h9: poll_period_ms = 10'd36;
      4'hA: poll_period_ms = 10'd40;
      4'hB: poll_period_ms = 10'd44;
      4'hC: poll_period_ms = 10'd52;
      4'hD: poll_period_ms = 10'd56;
      4'hE: poll_period_ms = 10'd60;
      4'hF: poll_period_ms = 10'd64;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- ms_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ms_interval_timer #(
  parameter int unsigned CYCLES_PER_MS = switch_cfg_pkg::CYCLES_PER_MS
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic [switch_cfg_pkg::MS_W-1:0] period_ms_i,
  output logic expire_o
);
  import switch_cfg_pkg::*;
  localparam int unsigned PRE_W = $clog2(CYCLES_PER_MS + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_MS - 1);

  logic [PRE_W-1:0] pre_reg;
  logic [MS_W-1:0] ms_reg;
  logic ms_tick;

  assign ms_tick = run_i && (pre_reg == PRE_LAST);

  // millisecond prescaler
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_reg <= '0;
    end else if (!run_i || ms_tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  // elapsed milliseconds, zero period never expires
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_reg <= '0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (!run_i) begin
        ms_reg <= '0;
      end else if (ms_tick) begin
        if (period_ms_i != '0 && ms_reg == period_ms_i - MS_W'(1)) begin
          ms_reg <= '0;
          expire_o <= 1'b1;
        end else begin
          ms_reg <= ms_reg + MS_W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- spi_frame_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module spi_frame_shifter (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [switch_cfg_pkg::FRAME_BITS-1:0] reply_word_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic frame_start_o,
  output logic frame_valid_o,
  output logic [switch_cfg_pkg::FRAME_BITS-1:0] frame_word_o
);
  import switch_cfg_pkg::*;
  localparam logic [5:0] FULL_COUNT = 6'(FRAME_BITS);

  logic sclk_prev_reg;
  logic cs_n_prev_reg;
  logic [FRAME_BITS-1:0] in_reg;
  logic [FRAME_BITS-1:0] out_reg;
  logic [5:0] count_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  assign sclk_rise = !cs_n_i && sclk_i && !sclk_prev_reg;
  assign sclk_fall = !cs_n_i && !sclk_i && sclk_prev_reg;
  assign cs_fall = !cs_n_i && cs_n_prev_reg;
  assign cs_rise = cs_n_i && !cs_n_prev_reg;
  assign frame_start_o = cs_fall;
  assign miso_o = out_reg[FRAME_BITS-1];
  assign miso_oe_o = !cs_n_i;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_prev_reg <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_i;
      cs_n_prev_reg <= cs_n_i;
    end
  end

  // sample on rising, shift out on falling
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_reg <= '0;
      out_reg <= '0;
      count_reg <= '0;
    end else if (cs_fall) begin
      out_reg <= reply_word_i;
      count_reg <= '0;
    end else begin
      if (sclk_rise) begin
        in_reg <= {in_reg[FRAME_BITS-2:0], mosi_i};
        count_reg <= (count_reg > FULL_COUNT) ? count_reg : count_reg + 6'(1);
      end
      if (sclk_fall) begin
        out_reg <= {out_reg[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // only exactly 32 bits make a frame
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_valid_o <= 1'b0;
      frame_word_o <= '0;
    end else begin
      frame_valid_o <= cs_rise && (count_reg == FULL_COUNT);
      if (cs_rise) begin
        frame_word_o <= in_reg;
      end
    end
  end
endmodule
`default_nettype wire

//--- switch_irq_lpm_config.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - a programmable input whose mask bit is zero never raises an interrupt on a change.
// - an input whose mask bit is one raises an interrupt whenever its switch changes in normal mode, never in low power.
// - the masks decide which inputs may interrupt while in normal mode.
// - the host may rewrite either mask at any time in normal mode and it takes effect.
// - after reset every implemented mask bit reads one.
// - the programmable mask sits in bits 7 to 0, bits 23 to 8 unused and zero.
// - the ground mask sits in bits 13 to 0, bits 23 to 14 unused and zero.
// - bits 7 to 4 of the low-power register select the wake timer and reset to 0000.
// - with a non-off timer code the device leaves low power on expiry and interrupts.
// - timer code 0000 disables the wake timer completely.
// - timer codes map to 6,12,24,48,96,192,394 ms and 4,8,16,32,64,128,256,512 ms.
// - bits 3 to 0 set the low-power polling interval and reset to 1111.
// - poll codes map to 3,6,12,24,48,68,76,128 ms and 32,36,40,44,52,56,60,64 ms.
// - each poll event turns on current sources for separate ground and battery windows.
// - the three registers decode at 7-bit addresses 0001_101, 0001_110 and 0001_111.
module switch_irq_lpm_config #(
  parameter int unsigned CYCLES_PER_MS = switch_cfg_pkg::CYCLES_PER_MS,
  parameter int unsigned GND_WINDOW_CYC = switch_cfg_pkg::GND_POLL_WINDOW_CYC,
  parameter int unsigned BAT_WINDOW_CYC = switch_cfg_pkg::BAT_POLL_WINDOW_CYC
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic [switch_cfg_pkg::SP_COUNT-1:0] programmable_input_bit_i,
  input wire logic [switch_cfg_pkg::SG_COUNT-1:0] ground_switch_input_bit_i,
  input wire logic fault_status_i,
  input wire logic enter_low_power_i,
  output logic int_n_o,
  output logic interrupt_pending_flag_o,
  output logic low_power_state_o,
  output logic ground_channel_poll_window_o,
  output logic battery_channel_poll_window_o
);
  import switch_cfg_pkg::*;
  localparam int unsigned WIN_W = $clog2((GND_WINDOW_CYC > BAT_WINDOW_CYC ?
    GND_WINDOW_CYC : BAT_WINDOW_CYC) + 1);
  localparam logic [WIN_W-1:0] GND_WIN_LAST = WIN_W'(GND_WINDOW_CYC - 1);
  localparam logic [WIN_W-1:0] BAT_WIN_LAST = WIN_W'(BAT_WINDOW_CYC - 1);

  logic [SP_COUNT-1:0] sp_mask_reg;
  logic [SG_COUNT-1:0] sg_mask_reg;
  logic [CODE_W-1:0] wake_code_reg;
  logic [CODE_W-1:0] poll_code_reg;
  logic [SP_COUNT-1:0] sp_prev_reg;
  logic [SG_COUNT-1:0] sg_prev_reg;
  logic [SP_COUNT-1:0] sp_change;
  logic [SG_COUNT-1:0] sg_change;
  logic irq_cause;
  logic flag_reg;
  power_mode_t mode_reg;
  logic frame_start;
  logic frame_valid;
  logic [FRAME_BITS-1:0] frame_word;
  logic [ADDR_W-1:0] frame_addr;
  logic frame_write;
  logic [DATA_W-1:0] frame_data;
  logic [DATA_W-1:0] read_data;
  logic [FRAME_BITS-1:0] reply_reg;
  logic wake_expire;
  logic poll_expire;
  logic in_lpm;
  logic [WIN_W-1:0] gnd_win_reg;
  logic [WIN_W-1:0] bat_win_reg;
  logic gnd_win_on_reg;
  logic bat_win_on_reg;

  spi_frame_shifter u_spi (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .mosi_i(mosi_i),
    .reply_word_i(reply_reg),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o),
    .frame_start_o(frame_start),
    .frame_valid_o(frame_valid),
    .frame_word_o(frame_word)
  );

  assign frame_addr = frame_word[ADDR_MSB:ADDR_LSB];
  assign frame_write = (frame_word[RW_BIT] == RW_WRITE);
  assign frame_data = frame_word[DATA_W-1:0];
  assign in_lpm = (mode_reg == LOW_POWER_MODE);

  // register writes
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_mask_reg <= SP_MASK_RESET;
      sg_mask_reg <= SG_MASK_RESET;
      wake_code_reg <= WAKE_CODE_RESET;
      poll_code_reg <= POLL_CODE_RESET;
    end else if (frame_valid && frame_write) begin
      unique case (frame_addr)
        ADDR_SP_IRQ_MASK: sp_mask_reg <= frame_data[SP_COUNT-1:0];
        ADDR_SG_IRQ_MASK: sg_mask_reg <= frame_data[SG_COUNT-1:0];
        ADDR_LPM_CONFIG: begin
          wake_code_reg <= frame_data[WAKE_LSB +: CODE_W];
          poll_code_reg <= frame_data[POLL_LSB +: CODE_W];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux, unused bits are zero
  always_comb begin
    read_data = '0;
    unique case (frame_addr)
      ADDR_SP_IRQ_MASK: read_data[SP_COUNT-1:0] = sp_mask_reg;
      ADDR_SG_IRQ_MASK: read_data[SG_COUNT-1:0] = sg_mask_reg;
      ADDR_LPM_CONFIG: begin
        read_data[WAKE_LSB +: CODE_W] = wake_code_reg;
        read_data[POLL_LSB +: CODE_W] = poll_code_reg;
      end
      default: read_data = '0;
    endcase
  end

  // reply for the next frame
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reply_reg <= '0;
    end else if (frame_valid) begin
      reply_reg <= {frame_word[ADDR_MSB:RW_BIT], fault_status_i, flag_reg,
                    read_data[REPLY_DATA_W-1:0]};
    end
  end

  // change detection
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_prev_reg <= '0;
      sg_prev_reg <= '0;
    end else begin
      sp_prev_reg <= programmable_input_bit_i;
      sg_prev_reg <= ground_switch_input_bit_i;
    end
  end

  assign sp_change = programmable_input_bit_i ^ sp_prev_reg;
  assign sg_change = ground_switch_input_bit_i ^ sg_prev_reg;
  // masked changes only count in normal mode
  assign irq_cause = !in_lpm &&
    (|(sp_change & sp_mask_reg) || |(sg_change & sg_mask_reg));

  // pending flag, set wins over the clear from a frame
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg <= 1'b0;
    end else if (irq_cause || (in_lpm && wake_expire)) begin
      flag_reg <= 1'b1;
    end else if (frame_valid) begin
      flag_reg <= 1'b0;
    end
  end

  assign interrupt_pending_flag_o = flag_reg;
  assign int_n_o = !flag_reg;

  // power mode
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg <= NORMAL_MODE;
    end else begin
      unique case (mode_reg)
        NORMAL_MODE: begin
          if (enter_low_power_i && cs_n_i) begin
            mode_reg <= LOW_POWER_MODE;
          end
        end
        LOW_POWER_MODE: begin
          if (wake_expire || frame_start) begin
            mode_reg <= NORMAL_MODE;
          end
        end
      endcase
    end
  end

  assign low_power_state_o = in_lpm;

  ms_interval_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_wake_timer (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .run_i(in_lpm && (wake_code_reg != WAKE_CODE_OFF)),
    .period_ms_i(wake_period_ms(wake_code_reg)),
    .expire_o(wake_expire)
  );

  ms_interval_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_poll_timer (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .run_i(in_lpm),
    .period_ms_i(poll_period_ms(poll_code_reg)),
    .expire_o(poll_expire)
  );

  // ground channel current window
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gnd_win_on_reg <= 1'b0;
      gnd_win_reg <= '0;
    end else if (!in_lpm) begin
      gnd_win_on_reg <= 1'b0;
      gnd_win_reg <= '0;
    end else if (poll_expire) begin
      gnd_win_on_reg <= 1'b1;
      gnd_win_reg <= '0;
    end else if (gnd_win_on_reg) begin
      gnd_win_on_reg <= (gnd_win_reg != GND_WIN_LAST);
      gnd_win_reg <= gnd_win_reg + WIN_W'(1);
    end
  end

  // battery channel current window
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bat_win_on_reg <= 1'b0;
      bat_win_reg <= '0;
    end else if (!in_lpm) begin
      bat_win_on_reg <= 1'b0;
      bat_win_reg <= '0;
    end else if (poll_expire) begin
      bat_win_on_reg <= 1'b1;
      bat_win_reg <= '0;
    end else if (bat_win_on_reg) begin
      bat_win_on_reg <= (bat_win_reg != BAT_WIN_LAST);
      bat_win_reg <= bat_win_reg + WIN_W'(1);
    end
  end

  assign ground_channel_poll_window_o = gnd_win_on_reg;
  assign battery_channel_poll_window_o = bat_win_on_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_masked_no_irq: assert property (
    !flag_reg && !wake_expire && !(|(sp_change & sp_mask_reg))
    && !(|(sg_change & sg_mask_reg)) |=> !flag_reg)
    else $error("interrupt raised without an enabled change");

  a_enabled_change_irq: assert property (
    !in_lpm && |(sp_change & sp_mask_reg) |=> flag_reg && !int_n_o)
    else $error("enabled change did not interrupt");

  a_lpm_masks_idle: assert property (
    in_lpm && !wake_expire && !flag_reg |=> !flag_reg)
    else $error("switch change interrupted in low power");

  a_sp_mask_write: assert property (
    frame_valid && frame_write && frame_addr == ADDR_SP_IRQ_MASK
    |=> sp_mask_reg == $past(frame_word[SP_COUNT-1:0]))
    else $error("programmable mask write not applied");

  a_reset_all_enabled: assert property (
    !$past(resetn_i) |-> sp_mask_reg == SP_MASK_RESET && sg_mask_reg == SG_MASK_RESET
      && poll_code_reg == POLL_CODE_RESET && wake_code_reg == WAKE_CODE_RESET)
    else $error("register reset value wrong");

  a_wake_exit_irq: assert property (
    in_lpm && wake_expire |=> !in_lpm ##0 flag_reg)
    else $error("wake expiry did not exit and interrupt");

  a_timer_off_silent: assert property (
    wake_expire |-> wake_code_reg != WAKE_CODE_OFF)
    else $error("wake timer fired while off");

  a_poll_window_start: assert property (
    in_lpm && poll_expire |=> ground_channel_poll_window_o && battery_channel_poll_window_o)
    else $error("poll event did not open current windows");

  a_unused_read_zero: assert property (
    frame_valid && frame_addr == ADDR_SG_IRQ_MASK
    |=> reply_reg[REPLY_DATA_W-1:SG_COUNT] == '0 && reply_reg[SG_COUNT-1:0] == $past(sg_mask_reg))
    else $error("ground mask readback wrong");

  a_lpm_cfg_read: assert property (
    frame_valid && frame_addr == ADDR_LPM_CONFIG
    |=> reply_reg[CODE_W*2-1:0] == $past({wake_code_reg, poll_code_reg}))
    else $error("low-power config readback wrong");

  a_sg_enabled_irq: assert property (
    !in_lpm && |(sg_change & sg_mask_reg) |=> flag_reg && !int_n_o)
    else $error("enabled ground change did not interrupt");

  a_sg_mask_write: assert property (
    frame_valid && frame_write && frame_addr == ADDR_SG_IRQ_MASK
    |=> sg_mask_reg == $past(frame_word[SG_COUNT-1:0]))
    else $error("ground mask write not applied");

  a_lpm_cfg_write: assert property (
    frame_valid && frame_write && frame_addr == ADDR_LPM_CONFIG
    |=> {wake_code_reg, poll_code_reg} == $past(frame_word[2*CODE_W-1:0]))
    else $error("low-power config write not applied");

  a_unmapped_write_ignored: assert property (
    frame_valid && frame_addr != ADDR_SP_IRQ_MASK && frame_addr != ADDR_SG_IRQ_MASK
    && frame_addr != ADDR_LPM_CONFIG |=> $stable(sp_mask_reg) && $stable(sg_mask_reg)
    && $stable({wake_code_reg, poll_code_reg}))
    else $error("unmapped address changed a register");

  a_sp_read_data: assert property (
    frame_valid && frame_addr == ADDR_SP_IRQ_MASK
    |=> reply_reg[REPLY_DATA_W-1:SP_COUNT] == '0 && reply_reg[SP_COUNT-1:0] == $past(sp_mask_reg))
    else $error("programmable mask readback wrong");

  a_reply_status_bits: assert property (
    frame_valid |=> reply_reg[FRAME_BITS-1:RW_BIT] == $past(frame_word[ADDR_MSB:RW_BIT])
    && reply_reg[REPLY_FAULT_BIT] == $past(fault_status_i)
    && reply_reg[REPLY_FLAG_BIT] == $past(flag_reg))
    else $error("reply header or status bits wrong");

  a_gnd_window_end: assert property (
    gnd_win_on_reg && gnd_win_reg == GND_WIN_LAST && !poll_expire |=> !gnd_win_on_reg)
    else $error("ground window too long");

  a_bat_window_end: assert property (
    bat_win_on_reg && bat_win_reg == BAT_WIN_LAST && !poll_expire |=> !bat_win_on_reg)
    else $error("battery window too long");

  a_gnd_window_hold: assert property (
    in_lpm && gnd_win_on_reg && gnd_win_reg != GND_WIN_LAST |=> gnd_win_on_reg)
    else $error("ground window closed early");

  a_bat_window_hold: assert property (
    in_lpm && bat_win_on_reg && bat_win_reg != BAT_WIN_LAST |=> bat_win_on_reg)
    else $error("battery window closed early");

  a_wake_off_stays: assert property (
    in_lpm && wake_code_reg == WAKE_CODE_OFF && !frame_start |=> in_lpm)
    else $error("left low power with the wake timer off");
endmodule
`default_nettype wire

//--- spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk_sys_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  logic busy;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    busy = 1'b0;
  end
  // idle data line toggles, no stale bit
  always @(negedge clk_sys_i) begin
    if (!busy) begin
      mosi_o <= ~mosi_o;
    end
  end
  // one frame msb first, any moment in normal mode
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge clk_sys_i);
    busy = 1'b1;
    @(negedge clk_sys_i);
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = tx[(63 - i) % 32];
      repeat (2) @(negedge clk_sys_i);
      sclk_o = 1'b1;
      rx = {rx[30:0], miso_i};
      repeat (2) @(negedge clk_sys_i);
      sclk_o = 1'b0;
    end
    repeat (2) @(negedge clk_sys_i);
    cs_n_o = 1'b1;
    busy = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

//--- switch_irq_lpm_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module switch_irq_lpm_config_test;
  import switch_cfg_pkg::*;
  localparam int unsigned CPM = 10;
  localparam int unsigned GWIN = 4;
  localparam int unsigned BWIN = 6;
  int wake_tab[16] = '{0, 6, 12, 24, 48, 96, 192, 394, 4, 8, 16, 32, 64, 128, 256, 512};
  int poll_tab[16] = '{3, 6, 12, 24, 48, 68, 76, 128, 32, 36, 40, 44, 52, 56, 60, 64};
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe, fault = 1'b0, enter_lp = 1'b0;
  logic [21:0] sw = 22'h0;
  logic int_n, flag, lp_state, gwin, bwin;
  logic [31:0] rx_word;
  int n_mismatch = 0;
  int checks_done = 0;
  int n, ng, nb;

  always #4 clk_sys = ~clk_sys;

  spi_host_model host (.clk_sys_i(clk_sys), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi));

  switch_irq_lpm_config #(.CYCLES_PER_MS(CPM), .GND_WINDOW_CYC(GWIN),
    .BAT_WINDOW_CYC(BWIN)) dut (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .programmable_input_bit_i(sw[7:0]),
    .ground_switch_input_bit_i(sw[21:8]), .fault_status_i(fault),
    .enter_low_power_i(enter_lp), .int_n_o(int_n), .interrupt_pending_flag_o(flag),
    .low_power_state_o(lp_state), .ground_channel_poll_window_o(gwin),
    .battery_channel_poll_window_o(bwin));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic access(input logic [6:0] a, input logic rw, input logic [23:0] d);
    host.xfer({a, rw, d}, 32, rx_word);
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [23:0] exp);
    access(a, 1'b0, 24'h0);
    access(a, 1'b0, 24'h0);
    check({24'h0, rx_word[31:24]}, {24'h0, a, 1'b0});
    check({10'h0, rx_word[21:0]}, {8'h0, exp});
  endtask

  task automatic poke(input logic [21:0] flip, input logic irq);
    @(negedge clk_sys);
    sw = sw ^ flip;
    repeat (4) @(negedge clk_sys);
    check({31'h0, int_n}, {31'h0, ~irq});
    check({31'h0, flag}, {31'h0, irq});
    access(ADDR_LPM_CONFIG, 1'b0, 24'h0);
    check({31'h0, int_n}, 32'h1);
  endtask

  task automatic enter_low;
    @(negedge clk_sys);
    enter_lp = 1'b1;
    @(negedge clk_sys);
    enter_lp = 1'b0;
    check({31'h0, lp_state}, 32'h1);
  endtask

  // sel 0 waits for wake-up, sel 1 for a poll window
  task automatic wait_for(input int sel, output int cnt);
    cnt = 0;
    while (cnt < 6000 && !(sel == 0 ? lp_state === 1'b0 : gwin === 1'b1)) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask

  task automatic in_range(input int got, input int exp);
    check({31'h0, got >= exp - 2 && got <= exp + 3}, 32'h1);
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({31'h0, miso_oe}, 32'h0);
    read_reg(ADDR_SP_IRQ_MASK, 24'h0000FF);
    read_reg(ADDR_SG_IRQ_MASK, 24'h003FFF);
    read_reg(ADDR_LPM_CONFIG, 24'h00000F);
    access(ADDR_SP_IRQ_MASK, RW_WRITE, 24'hFFFF5A);
    read_reg(ADDR_SP_IRQ_MASK, 24'h00005A);
    access(ADDR_SG_IRQ_MASK, RW_WRITE, 24'hFFC123);
    read_reg(ADDR_SG_IRQ_MASK, 24'h000123);
    access(ADDR_LPM_CONFIG, RW_WRITE, 24'hFFFF37);
    read_reg(ADDR_LPM_CONFIG, 24'h000037);
    access(7'h7F, RW_WRITE, 24'hFFFFFF);
    read_reg(7'h7F, 24'h000000);
    read_reg(ADDR_SP_IRQ_MASK, 24'h00005A);
    host.xfer({ADDR_SP_IRQ_MASK, RW_WRITE, 24'h000000}, 31, rx_word);
    read_reg(ADDR_SP_IRQ_MASK, 24'h00005A);
    host.xfer({ADDR_SP_IRQ_MASK, RW_WRITE, 24'h000000}, 33, rx_word);
    read_reg(ADDR_SP_IRQ_MASK, 24'h00005A);
    fault = 1'b1;
    read_reg(ADDR_LPM_CONFIG, 24'h000037);
    check({31'h0, rx_word[23]}, 32'h1);
    fault = 1'b0;
    access(ADDR_SP_IRQ_MASK, RW_WRITE, 24'h000001);
    access(ADDR_SG_IRQ_MASK, RW_WRITE, 24'h002000);
    poke(22'h000002, 1'b0);
    poke(22'h000001, 1'b1);
    poke(22'h000100, 1'b0);
    poke(22'h200000, 1'b1);
    access(ADDR_SP_IRQ_MASK, RW_WRITE, 24'h000000);
    poke(22'h000001, 1'b0);
    for (int c = 1; c < 16; c++) begin
      access(ADDR_LPM_CONFIG, RW_WRITE, {16'h0, c[3:0], 4'hF});
      enter_low();
      wait_for(0, n);
      in_range(n, wake_tab[c] * CPM);
      @(negedge clk_sys);
      check({31'h0, flag}, 32'h1);
      access(ADDR_LPM_CONFIG, 1'b0, 24'h0);
    end
    access(ADDR_SP_IRQ_MASK, RW_WRITE, 24'h0000FF);
    for (int c = 0; c < 16; c++) begin
      access(ADDR_LPM_CONFIG, RW_WRITE, {16'h0, 4'h0, c[3:0]});
      enter_low();
      sw = sw ^ 22'h000001;
      wait_for(1, n);
      in_range(n, poll_tab[c] * CPM + 1);
      ng = 0;
      nb = 0;
      for (int k = 0; k < 12; k++) begin
        ng += gwin === 1'b1;
        nb += bwin === 1'b1;
        @(negedge clk_sys);
      end
      check(ng, GWIN);
      check(nb, BWIN);
      check({30'h0, lp_state, int_n}, 32'h3);
      access(ADDR_LPM_CONFIG, 1'b0, 24'h0);
      check({31'h0, lp_state}, 32'h0);
    end
    summarize();
  end
endmodule
`default_nettype wire
